// ===== src/iedm_pkg.sv
package iedm_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int          IEDM_ADDR_W      = 8;
    localparam int          IEDM_DATA_W      = 32;
    localparam int          IEDM_STRB_W      = 4;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IEDM_SET_OFS     = 8'h00;
    localparam logic [7:0]  IEDM_CLR_OFS     = 8'h04;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] IEDM_IMPL_MASK   = 32'hffff_ffdf;
    localparam logic [31:0] IEDM_ENA_RESET   = 32'h0000_0000;
    localparam logic [31:0] IEDM_RDATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // response codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  IEDM_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  IEDM_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // channel state machines
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IEDM_WR_IDLE = 2'h1,
        IEDM_WR_RESP = 2'h2
    } iedm_wr_state_e;

    typedef enum logic [1:0] {
        IEDM_RD_IDLE = 2'h1,
        IEDM_RD_RESP = 2'h2
    } iedm_rd_state_e;

endpackage

// ===== src/iedm_enable_cell.sv
`timescale 1ns/1ps
module iedm_enable_cell #(
    parameter bit IMPL    = 1'b1,
    parameter bit RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    // bit commands
    input  wire logic set_in,
    input  wire logic clr_in,
    // stored enable
    output logic      state_out
);

    // unimplemented positions never leave zero
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !IMPL) begin
            state_out <= RST_VAL & IMPL;
        end else if (clr_in) begin
            state_out <= 1'b0;
        end else if (set_in) begin
            state_out <= 1'b1;
        end
    end

endmodule // iedm_enable_cell

// ===== src/iedm_interrupt_disable_mask_low.sv
`timescale 1ns/1ps
module iedm_interrupt_disable_mask_low
    import iedm_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   srst_in,

    // axi4-lite write address
    input  wire logic [IEDM_ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic [2:0]             s_axi_awprot_in,
    input  wire logic                   s_axi_awvalid_in,
    output logic                        s_axi_awready_out,

    // axi4-lite write data
    input  wire logic [IEDM_DATA_W-1:0] s_axi_wdata_in,
    input  wire logic [IEDM_STRB_W-1:0] s_axi_wstrb_in,
    input  wire logic                   s_axi_wvalid_in,
    output logic                        s_axi_wready_out,

    // axi4-lite write response
    output logic [1:0]                  s_axi_bresp_out,
    output logic                        s_axi_bvalid_out,
    input  wire logic                   s_axi_bready_in,

    // axi4-lite read address
    input  wire logic [IEDM_ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic [2:0]             s_axi_arprot_in,
    input  wire logic                   s_axi_arvalid_in,
    output logic                        s_axi_arready_out,

    // axi4-lite read data
    output logic [IEDM_DATA_W-1:0]      s_axi_rdata_out,
    output logic [1:0]                  s_axi_rresp_out,
    output logic                        s_axi_rvalid_out,
    input  wire logic                   s_axi_rready_in,

    // enable mask towards the controller
    output logic [IEDM_DATA_W-1:0]      interrupt_enable_mask_out
);

    // ------------------------------------------------------------------
    // write channel state
    // ------------------------------------------------------------------
    iedm_wr_state_e             wr_state_r;
    iedm_wr_state_e             wr_state_nxt;
    logic                       aw_held_r;
    logic                       aw_held_nxt;
    logic                       w_held_r;
    logic                       w_held_nxt;
    logic [IEDM_ADDR_W-1:0]     waddr_r;
    logic [IEDM_DATA_W-1:0]     wdata_r;
    logic [IEDM_STRB_W-1:0]     wstrb_r;
    logic                       awready_r;
    logic                       wready_r;
    logic                       bvalid_r;
    logic [1:0]                 bresp_r;

    // ------------------------------------------------------------------
    // read channel state
    // ------------------------------------------------------------------
    iedm_rd_state_e             rd_state_r;
    iedm_rd_state_e             rd_state_nxt;
    logic                       arready_r;
    logic                       rvalid_r;
    logic [IEDM_DATA_W-1:0]     rdata_r;
    logic [1:0]                 rresp_r;

    // ------------------------------------------------------------------
    // shared mask
    // ------------------------------------------------------------------
    logic [IEDM_DATA_W-1:0]     enable_bits;
    logic [IEDM_DATA_W-1:0]     interrupt_enable_set_bits;
    logic [IEDM_DATA_W-1:0]     interrupt_disable_bits;

    // ------------------------------------------------------------------
    // handshakes and commit
    // ------------------------------------------------------------------
    wire aw_hs  = s_axi_awvalid_in && awready_r;
    wire w_hs   = s_axi_wvalid_in && wready_r;
    wire b_hs   = bvalid_r && s_axi_bready_in;
    wire ar_hs  = s_axi_arvalid_in && arready_r;
    wire r_hs   = rvalid_r && s_axi_rready_in;
    wire commit = (wr_state_r == IEDM_WR_IDLE) && aw_held_r && w_held_r;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire w_is_set = waddr_r[IEDM_ADDR_W-1:2] == IEDM_SET_OFS[7:2];
    wire w_is_clr = waddr_r[IEDM_ADDR_W-1:2] == IEDM_CLR_OFS[7:2];
    wire r_is_set = s_axi_araddr_in[IEDM_ADDR_W-1:2] == IEDM_SET_OFS[7:2];
    wire r_is_clr = s_axi_araddr_in[IEDM_ADDR_W-1:2] == IEDM_CLR_OFS[7:2];
    wire w_mapped = w_is_set || w_is_clr;
    wire r_mapped = r_is_set || r_is_clr;

    // ------------------------------------------------------------------
    // byte lane masking
    // ------------------------------------------------------------------
    wire [IEDM_DATA_W-1:0] strb_bits = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                                        {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    // zeros and dropped lanes give no command; bit five masked off
    wire [IEDM_DATA_W-1:0] wr_ones = wdata_r & strb_bits
                                   & IEDM_IMPL_MASK;

    assign interrupt_enable_set_bits = (commit && w_is_set) ? wr_ones
                                     : '0;
    assign interrupt_disable_bits    = (commit && w_is_clr) ? wr_ones
                                     : '0;

    // ------------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------------
    wire [IEDM_DATA_W-1:0] rd_word  = r_mapped
                                    ? (enable_bits & IEDM_IMPL_MASK)
                                    : '0;
    wire [1:0]             rd_resp  = r_mapped ? IEDM_RESP_OKAY
                                               : IEDM_RESP_SLVERR;
    wire [1:0]             wr_resp  = w_mapped ? IEDM_RESP_OKAY
                                               : IEDM_RESP_SLVERR;

    // ------------------------------------------------------------------
    // write next state
    // ------------------------------------------------------------------
    assign aw_held_nxt = commit ? 1'b0 : (aw_held_r || aw_hs);
    assign w_held_nxt  = commit ? 1'b0 : (w_held_r || w_hs);

    always_comb begin
        wr_state_nxt = wr_state_r;
        case (wr_state_r)
            IEDM_WR_IDLE: begin
                if (commit) begin
                    wr_state_nxt = IEDM_WR_RESP;
                end
            end
            IEDM_WR_RESP: begin
                if (b_hs) begin
                    wr_state_nxt = IEDM_WR_IDLE;
                end
            end
            default: begin
                wr_state_nxt = IEDM_WR_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // read next state
    // ------------------------------------------------------------------
    always_comb begin
        rd_state_nxt = rd_state_r;
        case (rd_state_r)
            IEDM_RD_IDLE: begin
                if (ar_hs) begin
                    rd_state_nxt = IEDM_RD_RESP;
                end
            end
            IEDM_RD_RESP: begin
                if (r_hs) begin
                    rd_state_nxt = IEDM_RD_IDLE;
                end
            end
            default: begin
                rd_state_nxt = IEDM_RD_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // write channel registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            wr_state_r <= IEDM_WR_IDLE;
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            awready_r  <= 1'b0;
            wready_r   <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= IEDM_RESP_OKAY;
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_held_r  <= aw_held_nxt;
            w_held_r   <= w_held_nxt;
            awready_r  <= (wr_state_nxt == IEDM_WR_IDLE) && !aw_held_nxt;
            wready_r   <= (wr_state_nxt == IEDM_WR_IDLE) && !w_held_nxt;
            bvalid_r   <= wr_state_nxt == IEDM_WR_RESP;
            if (commit) begin
                bresp_r <= wr_resp;
            end
        end
    end

    // payload capture
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (aw_hs) begin
                waddr_r <= s_axi_awaddr_in;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // read channel registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rd_state_r <= IEDM_RD_IDLE;
            arready_r  <= 1'b0;
            rvalid_r   <= 1'b0;
            rdata_r    <= IEDM_RDATA_RESET;
            rresp_r    <= IEDM_RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            arready_r  <= rd_state_nxt == IEDM_RD_IDLE;
            rvalid_r   <= rd_state_nxt == IEDM_RD_RESP;
            if (ar_hs) begin
                rdata_r <= rd_word;
                rresp_r <= rd_resp;
            end
        end
    end

    // ------------------------------------------------------------------
    // enable storage, one cell per bit position
    // ------------------------------------------------------------------
    for (genvar i = 0; i < IEDM_DATA_W; i++) begin : g_ena
        iedm_enable_cell #(
            .IMPL    (IEDM_IMPL_MASK[i]),
            .RST_VAL (IEDM_ENA_RESET[i])
        ) u_cell (
            .core_clk_in (core_clk_in),
            .srst_in     (srst_in),
            .set_in      (interrupt_enable_set_bits[i]),
            .clr_in      (interrupt_disable_bits[i]),
            .state_out   (enable_bits[i])
        );
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_out         = awready_r;
    assign s_axi_wready_out          = wready_r;
    assign s_axi_bvalid_out          = bvalid_r;
    assign s_axi_bresp_out           = bresp_r;
    assign s_axi_arready_out         = arready_r;
    assign s_axi_rvalid_out          = rvalid_r;
    assign s_axi_rdata_out           = rdata_r;
    assign s_axi_rresp_out           = rresp_r;
    assign interrupt_enable_mask_out = enable_bits;

endmodule // iedm_interrupt_disable_mask_low

// ===== tb/iedm_chk.sv
`timescale 1ns/1ps
module iedm_chk
    import iedm_pkg::*;
(
    // watched ports
    input wire logic                   core_clk_in,
    input wire logic                   srst_in,
    input wire logic                   s_axi_awvalid_in,
    input wire logic                   s_axi_awready_out,
    input wire logic                   s_axi_wvalid_in,
    input wire logic                   s_axi_wready_out,
    input wire logic [1:0]             s_axi_bresp_out,
    input wire logic                   s_axi_bvalid_out,
    input wire logic                   s_axi_bready_in,
    input wire logic                   s_axi_arvalid_in,
    input wire logic                   s_axi_arready_out,
    input wire logic [IEDM_DATA_W-1:0] s_axi_rdata_out,
    input wire logic [1:0]             s_axi_rresp_out,
    input wire logic                   s_axi_rvalid_out,
    input wire logic                   s_axi_rready_in,
    input wire logic [IEDM_DATA_W-1:0] interrupt_enable_mask_out
);
    // ----------------------------------------
    // shorthands
    // ----------------------------------------
    wire        [31:0] msk = interrupt_enable_mask_out;
    wire        bv = s_axi_bvalid_out;
    wire        rv = s_axi_rvalid_out;
    wire        w_hs = s_axi_awvalid_in && s_axi_awready_out
                       && s_axi_wvalid_in && s_axi_wready_out;
    wire        ar_hs = s_axi_arvalid_in && s_axi_arready_out;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    bit_five_a: assert property (msk[5] == 1'b0)
        else $error("mask bit five set");
    mask_commit_a: assert property (!$past(srst_in) && $changed(msk)
        |-> $rose(bv)) else $error("mask changed outside commit");
    one_way_a: assert property ($rose(bv) |-> (msk & ~$past(msk)) == 0
        || ($past(msk) & ~msk) == 0) else $error("mask set and cleared");
    write_lat_a: assert property (w_hs |-> !bv ##1 !bv ##1 bv)
        else $error("write answer late or early");
    b_hold_a: assert property (bv && !s_axi_bready_in
        |=> bv && $stable(s_axi_bresp_out)) else $error("bresp dropped");
    read_lat_a: assert property (ar_hs |=> rv)
        else $error("read answer missing");
    r_hold_a: assert property (rv && !s_axi_rready_in
        |=> rv && $stable(s_axi_rdata_out)) else $error("rdata dropped");
    read_val_a: assert property ($rose(rv) && s_axi_rresp_out ==
        IEDM_RESP_OKAY |-> s_axi_rdata_out == $past(msk))
        else $error("read value not mask");
    err_zero_a: assert property (rv && s_axi_rresp_out ==
        IEDM_RESP_SLVERR |-> s_axi_rdata_out == 32'h0)
        else $error("error read not zero");

    cover property (w_hs);
    cover property (ar_hs);
    cover property (bv && s_axi_bresp_out == IEDM_RESP_SLVERR);
    cover property (bv && !s_axi_bready_in);
endmodule // iedm_chk

bind iedm_interrupt_disable_mask_low iedm_chk u_chk (.*);

// ===== tb/iedm_interrupt_disable_mask_low_tb.sv
`timescale 1ns/1ps
module iedm_interrupt_disable_mask_low_tb;
    import iedm_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        core_clk_in = 0, srst_in = 1;
    logic [7:0]  s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
    logic [2:0]  s_axi_awprot_in = 0, s_axi_arprot_in = 0;
    logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in = 0;
    logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
    logic        s_axi_bready_in = 0, s_axi_arvalid_in = 0;
    logic        s_axi_rready_in = 0, s_axi_awready_out, s_axi_wready_out;
    logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] interrupt_enable_mask_out, exp_mask = 0;
    logic [31:0] seed = 32'h10db16d7;
    int          n_mismatch = 0, samples_checked = 0;

    always #25 core_clk_in = ~core_clk_in;
    iedm_interrupt_disable_mask_low dut (.*);

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t word %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t resp %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge core_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        s_axi_bready_in <= seed[10];
        do begin
            @(posedge core_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 0;
            if (s_axi_bvalid_out === 1'b1 && !s_axi_bready_in)
                s_axi_bready_in <= 1;
        end while (!(s_axi_bvalid_out === 1'b1 && s_axi_bready_in));
        r = s_axi_bresp_out;
        s_axi_bready_in <= 0;
    endtask
    task automatic look(input logic [7:0] a);
        logic ok;
        @(posedge core_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in <= seed[11];
        do begin
            @(posedge core_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 0;
            if (s_axi_rvalid_out === 1'b1 && !s_axi_rready_in)
                s_axi_rready_in <= 1;
        end while (!(s_axi_rvalid_out === 1'b1 && s_axi_rready_in));
        s_axi_rready_in <= 0;
        ok = a[7:3] == 5'h0;
        chk_r(s_axi_rresp_out, ok ? IEDM_RESP_OKAY : IEDM_RESP_SLVERR);
        chk_w(s_axi_rdata_out, ok ? exp_mask : 32'h0);
    endtask
    // model: strobed, implemented bits only; set or clear by offset
    task automatic step(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        logic [31:0] eff;
        logic [1:0]  r;
        eff = d & IEDM_IMPL_MASK & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}},
                                    {8{s[0]}}};
        if (a[7:2] == IEDM_SET_OFS[7:2]) exp_mask = exp_mask | eff;
        if (a[7:2] == IEDM_CLR_OFS[7:2]) exp_mask = exp_mask & ~eff;
        wr(a, d, s, r);
        chk_r(r, a[7:3] == 5'h0 ? IEDM_RESP_OKAY : IEDM_RESP_SLVERR);
        chk_w(interrupt_enable_mask_out, exp_mask);
        look(seed[2] ? IEDM_CLR_OFS : IEDM_SET_OFS);
    endtask
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge core_clk_in);
        srst_in <= 0;
        @(posedge core_clk_in);
        chk_w(interrupt_enable_mask_out, IEDM_ENA_RESET);
        look(IEDM_SET_OFS);
        look(IEDM_CLR_OFS);
        step(IEDM_SET_OFS, 32'hffff_ffff, 4'hf);
        step(IEDM_CLR_OFS, 32'h0000_0000, 4'hf);
        step(IEDM_CLR_OFS, 32'h8000_0031, 4'hf);
        step(8'h08, 32'hffff_ffff, 4'hf);
        look(8'h0c);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(lfsr(seed));
            step({4'h0, seed[3] & seed[4], seed[5], seed[1:0]},
                 lfsr(seed), seed[9:6]);
        end
        @(posedge core_clk_in);
        srst_in <= 1;
        repeat (2) @(posedge core_clk_in);
        srst_in <= 0;
        exp_mask = 0;
        @(posedge core_clk_in);
        chk_w(interrupt_enable_mask_out, exp_mask);
        step(IEDM_SET_OFS, 32'h0000_00ff, 4'h1);
        results;
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        n_mismatch++;
        results;
    end
endmodule // iedm_interrupt_disable_mask_low_tb
